// file: design/sbt_edge_sync.sv
`timescale 1ns/1ps
module sbt_edge_sync (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Source level and mode
  input wire logic level_in,
  input wire logic resync,
  // Rising edge pulse
  output logic rise_pulse
);
  logic meta_q;
  logic sync_q;
  logic sync_prev_q;
  logic raw_prev_q;

  // Two-flop resampler; first stage feeds only the second
  always_ff @(posedge clock) begin
    if (reset) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
      sync_prev_q <= 1'b0;
    end else begin
      meta_q <= level_in;
      sync_q <= meta_q;
      sync_prev_q <= sync_q;
    end
  end

  // Direct path keeps two cycles less latency
  always_ff @(posedge clock) begin
    if (reset) begin
      raw_prev_q <= 1'b0;
    end else begin
      raw_prev_q <= level_in;
    end
  end

  // Edge select between resampled and direct input
  always_ff @(posedge clock) begin
    if (reset) begin
      rise_pulse <= 1'b0;
    end else if (resync) begin
      rise_pulse <= sync_q && !sync_prev_q;
    end else begin
      rise_pulse <= level_in && !raw_prev_q;
    end
  end

endmodule : sbt_edge_sync

// file: design/sbt_pkg.sv
package sbt_pkg;

  // ************************************************************
  // Register bus carrier
  // ************************************************************
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 16;

  typedef struct packed {
    logic [ADDR_WIDTH-1:0] addr;
    logic [DATA_WIDTH-1:0] wdata;
    logic wr;
    logic rd;
  } sbt_bus_req_type;

  // ************************************************************
  // Register offsets (byte addresses, one word each)
  // ************************************************************
  localparam logic [ADDR_WIDTH-1:0] OFS_CONTROL = 8'h00;
  localparam logic [ADDR_WIDTH-1:0] OFS_COUNT = 8'h04;
  localparam logic [ADDR_WIDTH-1:0] OFS_PERIOD = 8'h08;
  localparam logic [ADDR_WIDTH-1:0] OFS_IRQ_CTRL = 8'h0C;
  localparam logic [ADDR_WIDTH-1:0] OFS_STATUS = 8'h10;
  localparam logic [ADDR_WIDTH-1:0] OFS_MASK = 8'h14;

  // ************************************************************
  // Control register layout
  // ************************************************************
  typedef struct packed {
    logic timer_run;                 // bit 15
    logic rsv14;
    logic halt_in_idle;              // bit 13
    logic [2:0] rsv12_10;
    logic [1:0] extended_clock_pick; // bits 9-8
    logic rsv7;
    logic gated_accumulate;          // bit 6
    logic [1:0] prescale_ratio;      // bits 5-4
    logic rsv3;
    logic external_clock_resync;     // bit 2
    logic clock_source_pick;         // bit 1
    logic rsv0;
  } sbt_control_type;

  localparam logic [DATA_WIDTH-1:0] CONTROL_WRITE_MASK = 16'hA376;
  localparam logic [DATA_WIDTH-1:0] CONTROL_RESET = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] COUNT_RESET = 16'h0000;
  localparam logic [DATA_WIDTH-1:0] PERIOD_RESET = 16'h0000;

  // Extended clock source codes
  localparam logic [1:0] EXT_SECONDARY = 2'h0;
  localparam logic [1:0] EXT_TIMER_PIN = 2'h1;
  localparam logic [1:0] EXT_LOW_POWER_RC = 2'h2;
  localparam logic [1:0] EXT_GENERIC_PIN = 2'h3;

  // ************************************************************
  // Interrupt control and status layout
  // ************************************************************
  localparam int IRQ_ENABLE_BIT = 0;
  localparam int IRQ_PRIO_LSB = 1;
  localparam int STATUS_WIDTH = 2;
  localparam int STATUS_MATCH_BIT = 0;
  localparam int STATUS_GATE_FALL_BIT = 1;
  localparam logic [STATUS_WIDTH-1:0] STATUS_RESET = 2'h0;
  localparam logic [STATUS_WIDTH-1:0] MASK_RESET = 2'h0;
  localparam logic [2:0] PRIORITY_RESET = 3'h0;

  // ************************************************************
  // Prescaler ratios, as last count of the divider
  // ************************************************************
  localparam logic [7:0] PRESCALE_LAST_1 = 8'h00;
  localparam logic [7:0] PRESCALE_LAST_8 = 8'h07;
  localparam logic [7:0] PRESCALE_LAST_64 = 8'h3F;
  localparam logic [7:0] PRESCALE_LAST_256 = 8'hFF;

  // ************************************************************
  // Sequencer states
  // ************************************************************
  typedef enum logic [2:0] {
    ST_OFF = 3'b001,
    ST_RUN = 3'b010,
    ST_HALT = 3'b100
  } sbt_state_type;

  // Address match of one register slot
  function automatic logic sbt_hit(input logic [ADDR_WIDTH-1:0] addr,
                                   input logic [ADDR_WIDTH-1:0] offset);
    return addr == offset;
  endfunction : sbt_hit

endpackage : sbt_pkg

// file: design/sbt_prescaler.sv
`timescale 1ns/1ps
module sbt_prescaler (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Control
  input wire logic clear,
  input wire logic [1:0] ratio,
  // Ticks
  input wire logic tick_in,
  output logic tick_out
);
  import sbt_pkg::*;

  logic [7:0] count_q;
  logic [7:0] last;

  // Ratio code to last divider count
  always_comb begin
    case (ratio)
      2'h3: last = PRESCALE_LAST_256;
      2'h2: last = PRESCALE_LAST_64;
      2'h1: last = PRESCALE_LAST_8;
      default: last = PRESCALE_LAST_1;
    endcase
  end

  // Divider count, cleared so a new ratio starts clean
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      count_q <= 8'h00;
    end else if (tick_in) begin
      count_q <= (count_q == last) ? 8'h00 : count_q + 8'h01;
    end
  end

  // One output tick per full divide
  always_ff @(posedge clock) begin
    if (reset || clear) begin
      tick_out <= 1'b0;
    end else begin
      tick_out <= tick_in && (count_q == last);
    end
  end

endmodule : sbt_prescaler

// file: design/sbt_timer.sv
// Design decisions made here: the strobed register port and the register addresses.
`timescale 1ns/1ps
// Operation
// - Modes: internal-clock timer, synchronous counter, asynchronous counter of external clock.
// - Interrupt on period match, or on gate falling edge in gated mode.
// - Counter also serves as real-time clock time base, giving a tick output.
// - Control bit 15 starts the counter when set, stops it when clear.
// - Bits 9-8 pick the external source, only when clock source bit is set.
// - Selected clock is divided by the prescale ratio before the count advances.
// - Source bit, extended field and gate bit define clocking and gating.
// - Resync bit chooses resampled or direct counting of the external input.
// - Software-writable period register is compared with the count.
// - Interrupt has enable bit and three-bit priority; forwarded only when enabled.
// - Timer can keep operating in Idle or Sleep mode.
// - Unimplemented control bits read zero and ignore writes.
// - Prescale codes: 11 is 1:256, 10 is 1:64, 01 is 1:8, 00 is 1:1.
// - Gate bit enables gated accumulation on internal clock; ignored on external.
// - Resync bit works on external clock only; ignored on internal clock.
module sbt_timer (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Register bus
  input wire sbt_pkg::sbt_bus_req_type bus_req,
  output logic [sbt_pkg::DATA_WIDTH-1:0] rdata_q,
  // External clock sources, already timed to clock
  input wire logic secondary_clk_in,
  input wire logic timer_pin_clk_in,
  input wire logic low_power_rc_clk_in,
  input wire logic generic_pin_clk_in,
  // Gate input
  input wire logic gate_in,
  // Processor power state
  input wire logic idle_mode,
  input wire logic sleep_mode,
  // Interrupt
  output logic irq_q,
  output logic [2:0] timer_irq_priority_q,
  // Time base for the real-time clock
  output logic [sbt_pkg::DATA_WIDTH-1:0] count_q,
  output logic rtc_tick_q
);
  import sbt_pkg::*;

  // ************************************************************
  // Declarations
  // ************************************************************
  sbt_control_type control_q;
  logic [DATA_WIDTH-1:0] period_value_q;
  logic timer_irq_enable_q;
  logic [STATUS_WIDTH-1:0] status_q;
  logic [STATUS_WIDTH-1:0] mask_q;
  logic [STATUS_WIDTH-1:0] status_set;
  logic [STATUS_WIDTH-1:0] status_clear;
  sbt_state_type state_q;
  sbt_state_type state_d;
  logic gate_prev_q;
  logic ext_level;
  logic ext_rise;
  logic src_tick;
  logic count_enable;
  logic prescaled_tick;
  logic prescale_clear;
  logic period_match;
  logic gated_mode;
  logic async_count;
  logic wr_control;
  logic wr_count;
  logic wr_period;
  logic wr_irq_ctrl;
  logic wr_mask;
  logic rd_status;
  logic [DATA_WIDTH-1:0] read_word;

  // ************************************************************
  // Register decode
  // ************************************************************

  // Write and read strobes per register slot
  assign wr_control = bus_req.wr && sbt_hit(bus_req.addr, OFS_CONTROL);
  assign wr_count = bus_req.wr && sbt_hit(bus_req.addr, OFS_COUNT);
  assign wr_period = bus_req.wr && sbt_hit(bus_req.addr, OFS_PERIOD);
  assign wr_irq_ctrl = bus_req.wr && sbt_hit(bus_req.addr, OFS_IRQ_CTRL);
  assign wr_mask = bus_req.wr && sbt_hit(bus_req.addr, OFS_MASK);
  assign rd_status = bus_req.rd && sbt_hit(bus_req.addr, OFS_STATUS);

  // ************************************************************
  // Control register
  // ************************************************************

  // Only implemented bits take a write; the rest stay zero
  always_ff @(posedge clock) begin
    if (reset) begin
      control_q <= sbt_control_type'(CONTROL_RESET);
    end else if (wr_control) begin
      control_q <= sbt_control_type'(bus_req.wdata & CONTROL_WRITE_MASK);
    end
  end

  // ************************************************************
  // Period register
  // ************************************************************

  // Compare value for the count
  always_ff @(posedge clock) begin
    if (reset) begin
      period_value_q <= PERIOD_RESET;
    end else if (wr_period) begin
      period_value_q <= bus_req.wdata;
    end
  end

  // ************************************************************
  // Interrupt control and mask
  // ************************************************************

  // Enable bit and priority field
  always_ff @(posedge clock) begin
    if (reset) begin
      timer_irq_enable_q <= 1'b0;
      timer_irq_priority_q <= PRIORITY_RESET;
    end else if (wr_irq_ctrl) begin
      timer_irq_enable_q <= bus_req.wdata[IRQ_ENABLE_BIT];
      timer_irq_priority_q <= bus_req.wdata[IRQ_PRIO_LSB +: 3];
    end
  end

  // Per-event mask, same layout as status
  always_ff @(posedge clock) begin
    if (reset) begin
      mask_q <= MASK_RESET;
    end else if (wr_mask) begin
      mask_q <= bus_req.wdata[STATUS_WIDTH-1:0];
    end
  end

  // ************************************************************
  // Clock source selection
  // ************************************************************

  // Extended source only matters with the source bit set
  always_comb begin
    case (control_q.extended_clock_pick)
      EXT_TIMER_PIN: ext_level = timer_pin_clk_in;
      EXT_LOW_POWER_RC: ext_level = low_power_rc_clk_in;
      EXT_GENERIC_PIN: ext_level = generic_pin_clk_in;
      default: ext_level = secondary_clk_in;
    endcase
  end

  // Edge finder, resampled or direct on the resync bit
  // Limitation: changing the pick or resync bit while running can count one
  // false edge, as the edge history still holds the old source's level
  sbt_edge_sync u_edge_sync (
    .clock(clock),
    .reset(reset),
    .level_in(ext_level),
    .resync(control_q.external_clock_resync),
    .rise_pulse(ext_rise)
  );

  // Gating counts only on the internal clock
  assign gated_mode = !control_q.clock_source_pick && control_q.gated_accumulate;

  // Direct external counting keeps going while the core sleeps
  assign async_count = control_q.clock_source_pick && !control_q.external_clock_resync;

  // Source tick before the prescaler
  always_comb begin
    if (control_q.clock_source_pick) begin
      src_tick = ext_rise;
    end else if (gated_mode) begin
      src_tick = gate_in;
    end else begin
      src_tick = 1'b1;
    end
  end

  // ************************************************************
  // Run sequencer
  // ************************************************************

  // Off, counting, or held by a power state
  // Idle halts only on request; sleep halts every source but direct counting
  always_comb begin
    case (state_q)
      ST_OFF, ST_RUN, ST_HALT: begin
        if (!control_q.timer_run) begin
          state_d = ST_OFF;
        end else if (idle_mode && control_q.halt_in_idle) begin
          state_d = ST_HALT;
        end else if (sleep_mode && !async_count) begin
          state_d = ST_HALT;
        end else begin
          state_d = ST_RUN;
        end
      end
      default: begin
        state_d = ST_OFF;
      end
    endcase
  end

  // State register
  always_ff @(posedge clock) begin
    if (reset) begin
      state_q <= ST_OFF;
    end else begin
      state_q <= state_d;
    end
  end

  // ************************************************************
  // Prescaler
  // ************************************************************

  // Control write restarts the divider, as does stopping
  // Trade-off: a partial divide is lost, but the first period after a ratio
  // change is exact
  assign prescale_clear = wr_control || (state_q == ST_OFF);
  assign count_enable = (state_q == ST_RUN) && src_tick;

  // Divider 1, 8, 64 or 256
  sbt_prescaler u_prescaler (
    .clock(clock),
    .reset(reset),
    .clear(prescale_clear),
    .ratio(control_q.prescale_ratio),
    .tick_in(count_enable),
    .tick_out(prescaled_tick)
  );

  // ************************************************************
  // Counter
  // ************************************************************

  // Equality compare: a period set below the live count lets the counter run
  // on to the top and roll over once with no flag
  assign period_match = (count_q == period_value_q);

  // Software write wins over a tick in the same cycle
  // so a loaded value is never stepped in the cycle it lands
  always_ff @(posedge clock) begin
    if (reset) begin
      count_q <= COUNT_RESET;
    end else if (wr_count) begin
      count_q <= bus_req.wdata;
    end else if (prescaled_tick) begin
      count_q <= period_match ? COUNT_RESET : count_q + 16'h0001;
    end
  end

  // Wrap pulse for the real-time clock
  // A count load in the same cycle suppresses the pulse with the wrap
  always_ff @(posedge clock) begin
    if (reset) begin
      rtc_tick_q <= 1'b0;
    end else begin
      rtc_tick_q <= prescaled_tick && period_match && !wr_count;
    end
  end

  // ************************************************************
  // Gate edge tracking
  // ************************************************************

  // Previous gate level for falling edge
  // Reset level matches the idle low gate, so no false fall after reset
  always_ff @(posedge clock) begin
    if (reset) begin
      gate_prev_q <= 1'b0;
    end else begin
      gate_prev_q <= gate_in;
    end
  end

  // ************************************************************
  // Status and interrupt
  // ************************************************************

  // Event sources; gated mode reports the gate fall instead of match
  // The gate flag needs the run state, so a stopped timer stays quiet
  always_comb begin
    status_set = STATUS_RESET;
    status_set[STATUS_MATCH_BIT] = prescaled_tick && period_match && !wr_count
                                   && !gated_mode;
    status_set[STATUS_GATE_FALL_BIT] = gated_mode && (state_q == ST_RUN)
                                       && gate_prev_q && !gate_in;
  end

  // Read clears all bits
  assign status_clear = rd_status ? {STATUS_WIDTH{1'b1}} : STATUS_RESET;

  // Sticky flags; a new event beats the clearing read
  always_ff @(posedge clock) begin
    if (reset) begin
      status_q <= STATUS_RESET;
    end else begin
      status_q <= (status_q & ~status_clear) | status_set;
    end
  end

  // Level request, only while enabled and unmasked
  always_ff @(posedge clock) begin
    if (reset) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= timer_irq_enable_q && |(status_q & mask_q);
    end
  end

  // ************************************************************
  // Read path
  // ************************************************************

  // Word select; unmapped addresses read zero
  // Control reads back its masked copy, so reserved bits never show ones
  always_comb begin
    read_word = 16'h0000;
    case (bus_req.addr)
      OFS_CONTROL: read_word = control_q;
      OFS_COUNT: read_word = count_q;
      OFS_PERIOD: read_word = period_value_q;
      OFS_IRQ_CTRL: read_word = {12'h000, timer_irq_priority_q, timer_irq_enable_q};
      OFS_STATUS: read_word = {14'h0000, status_q};
      OFS_MASK: read_word = {14'h0000, mask_q};
      default: read_word = 16'h0000;
    endcase
  end

  // Data stand for exactly the cycle after the read strobe
  always_ff @(posedge clock) begin
    if (reset) begin
      rdata_q <= 16'h0000;
    end else if (bus_req.rd) begin
      rdata_q <= read_word;
    end else begin
      rdata_q <= 16'h0000;
    end
  end

endmodule : sbt_timer

// file: tb/sbt_timer_assertions.sv
`timescale 1ns/1ps
// ****
// Port checker
// ****
module sbt_timer_checker
  import sbt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Bus and power state
  input wire sbt_pkg::sbt_bus_req_type bus_req,
  input wire logic [sbt_pkg::DATA_WIDTH-1:0] rdata_q,
  input wire logic idle_mode,
  input wire logic sleep_mode,
  // Results
  input wire logic irq_q,
  input wire logic [2:0] timer_irq_priority_q,
  input wire logic [sbt_pkg::DATA_WIDTH-1:0] count_q,
  input wire logic rtc_tick_q
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic [15:0] ctl_q;
  logic en_q;
  logic [1:0] halt_q;
  logic wr_ctl, wr_cnt, halted, mapped;
  // Decodes seen from the bus side
  assign wr_ctl = bus_req.wr && bus_req.addr == OFS_CONTROL;
  assign wr_cnt = bus_req.wr && bus_req.addr == OFS_COUNT;
  assign mapped = bus_req.addr inside {8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14};
  // Async external counting is the only source that survives sleep
  assign halted = !ctl_q[15] || (idle_mode && ctl_q[13]) ||
                  (sleep_mode && !(ctl_q[1] && !ctl_q[2]));
  // Shadows of what software wrote
  always_ff @(posedge clock) begin
    if (reset) begin
      ctl_q <= 16'h0000;
      en_q <= 1'b0;
    end else begin
      if (wr_ctl) ctl_q <= bus_req.wdata & 16'hA376;
      if (bus_req.wr && bus_req.addr == OFS_IRQ_CTRL) en_q <= bus_req.wdata[0];
    end
  end
  // Cycles spent halted; three covers the tick pipeline draining
  always_ff @(posedge clock) begin
    if (reset || wr_ctl || wr_cnt || !halted) halt_q <= 2'h0;
    else if (halt_q != 2'h3) halt_q <= halt_q + 2'h1;
  end
  property p_read_idle;
    !$past(bus_req.rd) |-> rdata_q == 16'h0000;
  endproperty
  a_read_idle: assert property (p_read_idle) else $error("read data outside read");
  property p_ctrl_read;
    bus_req.rd && bus_req.addr == OFS_CONTROL |=> rdata_q == ctl_q;
  endproperty
  a_ctrl_read: assert property (p_ctrl_read) else $error("control readback");
  property p_unmapped;
    bus_req.rd && !mapped |=> rdata_q == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read");
  property p_prio;
    bus_req.wr && bus_req.addr == OFS_IRQ_CTRL |=>
      timer_irq_priority_q == $past(bus_req.wdata[3:1]);
  endproperty
  a_prio: assert property (p_prio) else $error("priority field");
  property p_irq_enable;
    !en_q && !$past(en_q) |-> !irq_q;
  endproperty
  a_irq_enable: assert property (p_irq_enable) else $error("irq while disabled");
  property p_halt_stable;
    halt_q == 2'h3 && halted && !wr_cnt |=> $stable(count_q);
  endproperty
  a_halt_stable: assert property (p_halt_stable) else $error("count moved halted");
  property p_count_step;
    !$past(wr_cnt) |-> count_q == $past(count_q) || count_q == $past(count_q) + 16'h0001
      || count_q == 16'h0000;
  endproperty
  a_count_step: assert property (p_count_step) else $error("count jump");
  property p_wrap_tick;
    count_q == 16'h0000 && $past(count_q) != 16'h0000 && !$past(wr_cnt) |-> rtc_tick_q;
  endproperty
  a_wrap_tick: assert property (p_wrap_tick) else $error("wrap without tick");
  property p_tick_zero;
    rtc_tick_q |-> count_q == 16'h0000;
  endproperty
  a_tick_zero: assert property (p_tick_zero) else $error("tick off wrap");
  c_tick: cover property (rtc_tick_q);
  c_irq: cover property (irq_q && timer_irq_priority_q != 3'h0);
  c_idle: cover property (halt_q == 2'h3 && idle_mode);
endmodule : sbt_timer_checker

bind sbt_timer sbt_timer_checker u_checker (.clock(clock), .reset(reset), .bus_req(bus_req),
  .rdata_q(rdata_q), .idle_mode(idle_mode), .sleep_mode(sleep_mode), .irq_q(irq_q),
  .timer_irq_priority_q(timer_irq_priority_q), .count_q(count_q), .rtc_tick_q(rtc_tick_q));

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
  import sbt_pkg::*;
  logic clock = 1'b0;
  logic reset = 1'b1;
  sbt_bus_req_type bus_req = '0;
  logic [15:0] rdata_q, count_q, v, w;
  logic [3:0] ext_q = 4'h0;
  logic gate_in = 1'b0;
  logic idle_mode = 1'b0;
  logic sleep_mode = 1'b0;
  logic irq_q, rtc_tick_q;
  logic [2:0] timer_irq_priority_q;
  integer fail_count = 0;
  integer compares = 0;
  integer seed = 14127;
  integer cycles = 0;
  integer i, j, n;
  int rise_q[$];

  // 20 MHz clock
  always #25 clock = ~clock;

  sbt_timer dut (.clock(clock), .reset(reset), .bus_req(bus_req), .rdata_q(rdata_q),
    .secondary_clk_in(ext_q[0]), .timer_pin_clk_in(ext_q[1]), .low_power_rc_clk_in(ext_q[2]),
    .generic_pin_clk_in(ext_q[3]), .gate_in(gate_in), .idle_mode(idle_mode),
    .sleep_mode(sleep_mode), .irq_q(irq_q), .timer_irq_priority_q(timer_irq_priority_q),
    .count_q(count_q), .rtc_tick_q(rtc_tick_q));

  // ****
  // Shared tasks
  // ****
  task automatic report_and_stop();
    $display("Compares %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : report_and_stop

  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    compares = compares + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task automatic wr(input logic [7:0] ad, input logic [15:0] d);
    @(posedge clock);
    bus_req.addr <= ad;
    bus_req.wdata <= d;
    bus_req.wr <= 1'b1;
    @(posedge clock);
    bus_req.wr <= 1'b0;
  endtask : wr

  // Data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] ad, output logic [15:0] d);
    @(posedge clock);
    bus_req.addr <= ad;
    bus_req.rd <= 1'b1;
    @(posedge clock);
    bus_req.rd <= 1'b0;
    #1 d = rdata_q;
  endtask : rd

  task automatic wait_tick(output integer k);
    k = 0;
    do begin
      @(posedge clock);
      #1 k = k + 1;
    end while (rtc_tick_q !== 1'b1 && k < 300);
  endtask : wait_tick

  // Hang guard, far above the few thousand cycles needed
  always @(posedge clock) begin
    cycles = cycles + 1;
    if (cycles == 20000) begin
      fail_count = fail_count + 1;
      report_and_stop();
    end
  end

  // ****
  // Scenarios
  // ****
  initial begin
    repeat (10) @(posedge clock);
    reset <= 1'b0;
    for (i = 0; i < 7; i++) begin
      rd(8'(i * 4), v);
      check("reset value", 16'h0000, v);
    end
    for (i = 0; i < 4; i++) begin
      w = $random(seed) & 16'h7FFF;
      wr(OFS_CONTROL, w);
      rd(OFS_CONTROL, v);
      check("control", w & 16'hA376, v);
      w = $random(seed);
      wr(OFS_PERIOD, w);
      wr(8'h18, w);
      rd(OFS_PERIOD, v);
      check("period", w, v);
    end
    // Steady tick spacing per ratio
    wr(OFS_PERIOD, 16'hFFFF);
    for (i = 0; i < 4; i++) begin
      n = (i == 0) ? 1 : (i == 1) ? 8 : (i == 2) ? 64 : 256;
      wr(OFS_CONTROL, 16'h8000 | 16'(i << 4));
      repeat (4 * n) @(posedge clock);
      rd(OFS_COUNT, v);
      repeat (4 * n - 2) @(posedge clock);
      rd(OFS_COUNT, w);
      check("prescaled step", v + 16'd4, w);
    end
    // Stopped, idle with halt, idle without halt, sleep on internal clock
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      idle_mode <= (i == 1 || i == 2);
      sleep_mode <= (i == 3);
      wr(OFS_CONTROL, (i == 0) ? 16'h0000 : (i == 1) ? 16'hA000 : 16'h8000);
      repeat (4) @(posedge clock);
      rd(OFS_COUNT, v);
      repeat (8) @(posedge clock);
      rd(OFS_COUNT, w);
      check("power count", (i == 2) ? v + 16'd10 : v, w);
    end
    @(posedge clock);
    idle_mode <= 1'b0;
    sleep_mode <= 1'b0;
    // Period match and interrupt path
    j = $random(seed) & 7;
    wr(OFS_IRQ_CTRL, 16'(j << 1) | 16'h0001);
    wr(OFS_MASK, 16'h0001);
    wr(OFS_PERIOD, 16'h0005);
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_CONTROL, 16'h8000);
    wait_tick(n);
    wait_tick(n);
    check("period length", 16'd6, 16'(n));
    check("wrap value", 16'h0000, count_q);
    repeat (2) @(posedge clock);
    #1 check("irq", 16'h0001, 16'(irq_q));
    check("priority", 16'(j), 16'(timer_irq_priority_q));
    wr(OFS_CONTROL, 16'h0000);
    repeat (4) @(posedge clock);
    rd(OFS_STATUS, v);
    check("status", 16'h0001, v);
    rd(OFS_STATUS, v);
    check("status cleared", 16'h0000, v);
    @(posedge clock);
    #1 check("irq cleared", 16'h0000, 16'(irq_q));
    // Masked, then disabled: no request leaves
    for (i = 0; i < 2; i++) begin
      wr(OFS_MASK, 16'(i));
      wr(OFS_IRQ_CTRL, 16'(1 - i));
      wr(OFS_CONTROL, 16'h8000);
      wait_tick(n);
      repeat (2) @(posedge clock);
      #1 check("irq blocked", 16'h0000, 16'(irq_q));
      wr(OFS_CONTROL, 16'h0000);
      repeat (4) @(posedge clock);
      rd(OFS_STATUS, v);
    end
    // External sources, both resync settings, gate bit set but ignored
    // Odd passes run asleep: only direct external counting survives
    wr(OFS_PERIOD, 16'hFFFF);
    for (i = 0; i < 8; i++) begin
      wr(OFS_COUNT, 16'h0000);
      sleep_mode <= (i & 1) != 0;
      wr(OFS_CONTROL, 16'h8042 | 16'((i & 3) << 8) | 16'((i >> 2) << 2));
      repeat (4) @(posedge clock);
      rise_q = {};
      for (j = 0; j < 40; j++) begin
        @(posedge clock);
        w = $random(seed);
        ext_q <= w[3:0];
        if (w[i & 3] && !ext_q[i & 3]) rise_q.push_back(j);
      end
      @(posedge clock);
      ext_q <= 4'h0;
      repeat (6) @(posedge clock);
      wr(OFS_CONTROL, 16'h0000);
      sleep_mode <= 1'b0;
      rd(OFS_COUNT, v);
      w = (i > 4 && (i & 1) != 0) ? 16'h0000 : 16'(rise_q.size());
      check("edge count", w, v);
    end
    // Gated accumulation and gate fall flag
    wr(OFS_COUNT, 16'h0000);
    wr(OFS_MASK, 16'h0002);
    wr(OFS_IRQ_CTRL, 16'h0001);
    wr(OFS_CONTROL, 16'h8040);
    n = 5 + ($random(seed) & 15);
    repeat (5) @(posedge clock);
    gate_in <= 1'b1;
    repeat (n) @(posedge clock);
    gate_in <= 1'b0;
    repeat (6) @(posedge clock);
    #1 check("gate irq", 16'h0001, 16'(irq_q));
    rd(OFS_COUNT, v);
    check("gated count", 16'(n), v);
    rd(OFS_STATUS, v);
    check("gate status", 16'h0002, v);
    report_and_stop();
  end
endmodule : testbench
